// File: hdl/tam_top.sv
`timescale 1ns/1ps
// Function
// - only channels selected for measurement are checked against limits.
// - a sample above upper or below lower limit by more than the hysteresis is a violation.
// - alarm only after violation lasts longer than the selected (normal or defrost) delay.
// - violation stays until the value is back between both limits by at least the hysteresis.
// - contact closes only when distance past a limit exceeds hysteresis, and without latching opens once back inside by at least it.
// - defrost check on and defrost input closed selects defrost delay.
// - limits are evaluated only with the channel's alarm enable on.
// - without latching, contact is closed exactly while the alarm persists.
// - self-sustaining mode keeps contact closed until a manual reset.
// - self-sustaining mode shows the alarm text until a manual reset.
// - reset-alarm command clears latched contact and text only if no alarm is present in that cycle, with acknowledge.
// - humidity variant sounds the buzzer during every alarm, no override.
// - temperature variant gates the buzzer by a software on/off bit.
module tam_top #(
  parameter bit HUMID_VARIANT = 1'b0,
  parameter int TICK_CYCLES = tam_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tam_pkg::tam_sample_t sample,
  input wire logic sample_valid,
  input wire logic defrost_input,
  output logic alarm_contact,
  output logic buzzer,
  output logic alarm_text,
  output logic alarm_ack
);
  import tam_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a[1:0] == 2'b00 && (a <= OFS_DLY_DEF || (a >= OFS_LIM_BASE && a <= OFS_LIM_END));
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [11:0] ctrl_reg;
  logic [15:0] hyst_reg;
  logic [15:0] dly_norm_reg;
  logic [15:0] dly_def_reg;
  tam_limits_t lim_reg [NCH];
  logic rst_cmd_reg;

  logic latch_mode;
  logic defrost_check;
  logic buzzer_en;
  logic [3:0] chan_sel;
  logic [3:0] alarm_en;

  assign latch_mode = ctrl_reg[CTRL_LATCH_BIT];
  assign defrost_check = ctrl_reg[CTRL_DEFCHK_BIT];
  assign buzzer_en = ctrl_reg[CTRL_BUZ_BIT];
  assign chan_sel = ctrl_reg[CTRL_SEL_LSB +: 4];
  assign alarm_en = ctrl_reg[CTRL_EN_LSB +: 4];

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;

  // address and data may come in either order; commit once both are held
  assign do_write = aw_held_reg && w_held_reg;

  always_comb begin
    aw_held_next = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) && !do_write;
    w_held_next = (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !do_write;
    bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      hyst_reg <= HYST_RST;
      dly_norm_reg <= DLY_RST;
      dly_def_reg <= DLY_RST;
      rst_cmd_reg <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        lim_reg[i].lower <= LOWER_RST;
        lim_reg[i].upper <= UPPER_RST;
      end
    end else begin
      rst_cmd_reg <= 1'b0;
      if (do_write) begin
        unique case (aw_addr_reg)
          OFS_CTRL: ctrl_reg <= 12'(merge({20'h00000, ctrl_reg}, wdata_reg, wstrb_reg));
          OFS_CMD: rst_cmd_reg <= wstrb_reg[0] && wdata_reg[CMD_RESET_BIT];
          OFS_HYST: hyst_reg <= 16'(merge({16'h0000, hyst_reg}, wdata_reg, wstrb_reg));
          OFS_DLY_NORM: dly_norm_reg <= 16'(merge({16'h0000, dly_norm_reg}, wdata_reg, wstrb_reg));
          OFS_DLY_DEF: dly_def_reg <= 16'(merge({16'h0000, dly_def_reg}, wdata_reg, wstrb_reg));
          default: begin
            for (int i = 0; i < NCH; i++) begin
              if (aw_addr_reg == OFS_LIM_BASE + 8'(i * 8)) begin
                lim_reg[i].lower <= 16'(merge({16'h0000, lim_reg[i].lower}, wdata_reg,
                                              wstrb_reg));
              end
              if (aw_addr_reg == OFS_LIM_BASE + 8'(i * 8 + 4)) begin
                lim_reg[i].upper <= 16'(merge({16'h0000, lim_reg[i].upper}, wdata_reg,
                                              wstrb_reg));
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // defrost input synchroniser
  // ----------------------------------------
  logic def_s1_reg;
  logic def_s2_reg;
  logic def_s3_reg;
  logic defrost_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      def_s1_reg <= 1'b0;
      def_s2_reg <= 1'b0;
      def_s3_reg <= 1'b0;
      defrost_reg <= 1'b0;
    end else begin
      def_s1_reg <= defrost_input;
      def_s2_reg <= def_s1_reg;
      def_s3_reg <= def_s2_reg;
      if (def_s2_reg == def_s3_reg) begin
        defrost_reg <= def_s3_reg;
      end
    end
  end

  // ----------------------------------------
  // delay time base
  // ----------------------------------------
  logic [31:0] tick_cnt_reg;
  logic tick_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                                                             : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  logic [15:0] delay_sel;
  tam_chan_state_t ch_state [NCH];
  logic [NCH-1:0] ch_alarm;
  logic [NCH-1:0] ch_viol;

  // defrost delay replaces the normal one while defrost check is on and the defrost input is closed
  assign delay_sel = (defrost_check && defrost_reg) ? dly_def_reg : dly_norm_reg;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tam_channel u_ch (
      .ref_clk(ref_clk),
      .rst(rst),
      .active(chan_sel[g] && alarm_en[g]),
      .sample_hit(sample_valid && sample.chan == 2'(g)),
      .value(sample.value),
      .limits(lim_reg[g]),
      .hyst(hyst_reg),
      .delay(delay_sel),
      .tick(tick_reg),
      .state(ch_state[g])
    );
    assign ch_alarm[g] = ch_state[g].alarm;
    assign ch_viol[g] = ch_state[g].violation;
  end

  // ----------------------------------------
  // contact, text and buzzer
  // ----------------------------------------
  logic any_alarm;
  logic latched_reg;
  logic latched_next;
  logic contact_next;

  assign any_alarm = |ch_alarm;

  // a fresh alarm wins over a reset in the same cycle, so none is lost
  assign latched_next = (latched_reg && !rst_cmd_reg) || (latch_mode && any_alarm);
  assign contact_next = any_alarm || latched_next;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latched_reg <= 1'b0;
      alarm_contact <= 1'b0;
      alarm_text <= 1'b0;
      alarm_ack <= 1'b0;
      buzzer <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      alarm_contact <= contact_next;
      alarm_text <= latched_next;
      alarm_ack <= rst_cmd_reg;
      buzzer <= contact_next && (HUMID_VARIANT || buzzer_en);
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic rvalid_next;
  logic [31:0] rd_word;

  assign rvalid_next = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_word = {20'h00000, ctrl_reg};
      OFS_STATUS: rd_word = {21'h000000, defrost_reg, latched_reg, alarm_contact,
                             ch_alarm, ch_viol};
      OFS_HYST: rd_word = {16'h0000, hyst_reg};
      OFS_DLY_NORM: rd_word = {16'h0000, dly_norm_reg};
      OFS_DLY_DEF: rd_word = {16'h0000, dly_def_reg};
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (s_axi_araddr == OFS_LIM_BASE + 8'(i * 8)) begin
            rd_word = {{16{lim_reg[i].lower[15]}}, lim_reg[i].lower};
          end
          if (s_axi_araddr == OFS_LIM_BASE + 8'(i * 8 + 4)) begin
            rd_word = {{16{lim_reg[i].upper[15]}}, lim_reg[i].upper};
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_plain_contact: assert property (
    @(posedge ref_clk) disable iff (rst) !latched_reg && !any_alarm && !latch_mode
      |=> !alarm_contact)
    else $error("contact closed without alarm in plain mode");
  a_or_drives_contact: assert property (
    @(posedge ref_clk) disable iff (rst) any_alarm |=> alarm_contact)
    else $error("channel alarm did not close contact");
  a_latch_holds: assert property (
    @(posedge ref_clk) disable iff (rst) latched_reg && !rst_cmd_reg
      |=> latched_reg && alarm_contact && alarm_text)
    else $error("latched alarm released without reset");
  a_reset_clears: assert property (
    @(posedge ref_clk) disable iff (rst) rst_cmd_reg && !any_alarm
      |=> !alarm_text && alarm_ack && !alarm_contact)
    else $error("reset command did not clear latched alarm");
  a_buzzer_gate: assert property (
    @(posedge ref_clk) disable iff (rst) buzzer |-> alarm_contact)
    else $error("buzzer on without alarm");
  a_buzzer_muted: assert property (
    @(posedge ref_clk) disable iff (rst) !HUMID_VARIANT && !buzzer_en |=> !buzzer)
    else $error("buzzer on while switched off");
  a_buzzer_forced: assert property (
    @(posedge ref_clk) disable iff (rst) HUMID_VARIANT && alarm_contact |-> buzzer)
    else $error("humidity variant buzzer silent during alarm");
  a_defrost_delay: assert property (
    @(posedge ref_clk) disable iff (rst) defrost_check && defrost_reg |-> delay_sel == dly_def_reg)
    else $error("defrost delay not selected");

endmodule

// File: shared/tam_pkg.sv
package tam_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int NCH = 4;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_HYST = 8'h0c;
  localparam logic [7:0] OFS_DLY_NORM = 8'h10;
  localparam logic [7:0] OFS_DLY_DEF = 8'h14;
  localparam logic [7:0] OFS_LIM_BASE = 8'h20;
  localparam logic [7:0] OFS_LIM_END = 8'h3c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_DEFCHK_BIT = 1;
  localparam int CTRL_BUZ_BIT = 2;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_EN_LSB = 8;
  localparam int CTRL_W = 12;
  localparam int CMD_RESET_BIT = 0;

  // ----------------------------------------
  // reset values and bus answers
  // ----------------------------------------
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [15:0] HYST_RST = 16'h0000;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [15:0] UPPER_RST = 16'h7fff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] chan;
    logic signed [15:0] value;
  } tam_sample_t;

  typedef struct packed {
    logic signed [15:0] lower;
    logic signed [15:0] upper;
  } tam_limits_t;

  typedef struct packed {
    logic violation;
    logic alarm;
  } tam_chan_state_t;

  typedef enum logic [1:0] {CH_OK, CH_WAIT, CH_ALARM} tam_chan_st_t;

endpackage

// File: hdl/tam_channel.sv
`timescale 1ns/1ps
module tam_channel (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic active,
  input wire logic sample_hit,
  input wire logic signed [15:0] value,
  input wire tam_pkg::tam_limits_t limits,
  input wire logic [15:0] hyst,
  input wire logic [15:0] delay,
  input wire logic tick,
  output tam_pkg::tam_chan_state_t state
);
  import tam_pkg::*;

  // ----------------------------------------
  // band test
  // ----------------------------------------
  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  logic signed [17:0] v_x;
  logic signed [17:0] up_x;
  logic signed [17:0] lo_x;
  logic signed [17:0] h_x;
  logic out_band;
  logic in_band;

  assign v_x = sx(value);
  assign up_x = sx(limits.upper);
  assign lo_x = sx(limits.lower);
  assign h_x = {2'b00, hyst};
  // trip and release points both sit a hysteresis away from the limit
  assign out_band = (v_x > up_x + h_x) || (v_x < lo_x - h_x);
  assign in_band = (v_x <= up_x - h_x) && (v_x >= lo_x + h_x);

  // ----------------------------------------
  // state and delay
  // ----------------------------------------
  tam_chan_st_t st_reg;
  tam_chan_st_t st_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb begin
    st_next = st_reg;
    if (!active) begin
      st_next = CH_OK;
    end else begin
      unique case (st_reg)
        CH_OK: begin
          if (sample_hit && out_band) begin
            st_next = CH_WAIT;
          end
        end
        CH_WAIT: begin
          if (sample_hit && in_band) begin
            st_next = CH_OK;
          end else if (cnt_reg > delay) begin
            st_next = CH_ALARM;
          end
        end
        CH_ALARM: begin
          if (sample_hit && in_band) begin
            st_next = CH_OK;
          end
        end
      endcase
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (st_next != CH_WAIT) begin
      cnt_next = 16'h0000;
    end else if (tick && cnt_reg != 16'hffff) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= CH_OK;
      cnt_reg <= 16'h0000;
      state <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      state.violation <= (st_next != CH_OK);
      state.alarm <= (st_next == CH_ALARM);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_off_stays_quiet: assert property (
    @(posedge ref_clk) disable iff (rst) !active |=> !state.violation && !state.alarm)
    else $error("inactive channel shows violation or alarm");
  a_alarm_after_delay: assert property (
    @(posedge ref_clk) disable iff (rst) $rose(state.alarm) |-> $past(cnt_reg) > $past(delay))
    else $error("alarm raised before delay elapsed");
  a_delay_restarts: assert property (
    @(posedge ref_clk) disable iff (rst) st_reg == CH_OK |-> cnt_reg == 16'h0000)
    else $error("delay count kept while in range");
  a_out_band_trips: assert property (
    @(posedge ref_clk) disable iff (rst)
      active && sample_hit && st_reg == CH_OK && out_band |=> state.violation)
    else $error("out of band sample not flagged");
  a_in_band_clears: assert property (
    @(posedge ref_clk) disable iff (rst)
      active && sample_hit && st_reg != CH_OK && in_band |=> !state.violation && !state.alarm)
    else $error("in band sample did not clear violation");

endmodule

// File: tb/tam_signal_dev.sv
`timescale 1ns/1ps
// ----------------------------------------
// external signalling unit on the contact
// ----------------------------------------
module tam_signal_dev (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic contact,
  input wire logic buzzer,
  output logic [15:0] closures,
  output logic sounding
);
  logic contact_reg;

  // counts closures so a flash unit sees each new alarm once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      contact_reg <= 1'h0;
      closures <= '0;
    end else begin
      contact_reg <= contact;
      if (contact && !contact_reg) begin
        closures <= closures + 16'h1;
      end
    end
  end

  assign sounding = contact & buzzer;
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import tam_pkg::*;
  logic ref_clk;
  logic rst = 1'h1;
  logic [7:0] aw_a = '0, ar_a = '0;
  logic [31:0] w_d = '0, r_d, got;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, contact, buzz, text, ack, sounding;
  logic buzz_h;
  int n_ack = 0, n_cl = 0;
  logic [1:0] b_resp, r_resp, rsp;
  logic [15:0] closures;
  tam_sample_t smp_in = '0;
  logic smp_v = 1'h0, defrost = 1'h0;
  int n_errors = 0, n_checks = 0, seed = 13, v;
  int hv[4] = '{105, 115, 95, 85};
  logic he[4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  logic [31:0] ctl[2] = '{32'h314, 32'h134};

  tam_top #(.TICK_CYCLES(4)) i_tam_top (
    .ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sample(smp_in), .sample_valid(smp_v), .defrost_input(defrost),
    .alarm_contact(contact), .buzzer(buzz), .alarm_text(text), .alarm_ack(ack)
  );

  // second copy only to watch the forced buzzer of the humidity variant
  tam_top #(.HUMID_VARIANT(1'b1), .TICK_CYCLES(4)) i_tam_top_humid (
    .ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(r_r),
    .sample(smp_in), .sample_valid(smp_v), .defrost_input(defrost),
    .alarm_contact(), .buzzer(buzz_h), .alarm_text(), .alarm_ack()
  );

  tam_signal_dev i_tam_signal_dev (
    .ref_clk(ref_clk), .rst(rst), .contact(contact), .buzzer(buzz),
    .closures(closures), .sounding(sounding)
  );

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ack is a one-cycle pulse that may pass while the write task waits
  always @(posedge ref_clk) begin
    if (ack) begin
      n_ack <= n_ack + 1;
    end
  end

  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ap, wp;
    ap = 1'h1;
    wp = 1'h1;
    rs = 'x;
    @(posedge ref_clk);
    aw_a <= a; w_d <= d; aw_v <= 1'h1; w_v <= 1'h1; b_r <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (ap && aw_rdy) begin ap = 1'h0; aw_v <= 1'h0; end
      if (wp && w_rdy) begin wp = 1'h0; w_v <= 1'h0; end
      if (b_v) begin rs = b_resp; b_r <= 1'h0; break; end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    d = 'x;
    rs = 'x;
    @(posedge ref_clk);
    ar_a <= a; ar_v <= 1'h1; r_r <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (ar_v && ar_rdy) ar_v <= 1'h0;
      if (r_v) begin d = r_d; rs = r_resp; r_r <= 1'h0; break; end
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    wr(a, d, rs);
    chk(rs, RESP_OKAY, "bresp");
  endtask

  task automatic send(input logic [1:0] c, input int val);
    @(posedge ref_clk);
    smp_in <= '{chan: c, value: 16'(val)};
    smp_v <= 1'h1;
    @(posedge ref_clk);
    smp_v <= 1'h0;
  endtask

  // bounded wait, the caller compares the level afterwards
  task automatic wait_c(input logic e, input int n);
    repeat (n) begin
      if (contact === e) break;
      @(posedge ref_clk);
    end
  endtask

  function automatic logic out_rng(input int x, input int lo, input int hi);
    return x > hi || x < lo;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    rd(OFS_CTRL, got, rsp); chk(got, 32'h0, "ctrl reset");
    rd(OFS_LIM_BASE, got, rsp); chk(got, 32'hffff8000, "lower reset");
    rd(8'h24, got, rsp); chk(got, 32'h00007fff, "upper reset");
    rd(8'h18, got, rsp); chk(rsp, RESP_SLVERR, "unmapped");
    for (int c = 0; c < 2; c++) begin
      wreg(8'(OFS_LIM_BASE + 8 * c), 32'hffffff9c);
      wreg(8'(OFS_LIM_BASE + 8 * c + 4), 32'h64);
    end
    wreg(OFS_DLY_NORM, 32'h2);
    wreg(OFS_DLY_DEF, 32'h14);
    wreg(OFS_HYST, 32'h0);
    wreg(OFS_CTRL, 32'h334);
    repeat (12) begin
      v = $random(seed) % 200;
      send(2'h0, v);
      rd(OFS_STATUS, got, rsp); chk(got[0], out_rng(v, -100, 100), "viol");
    end
    send(2'h0, 0);
    wait_c(1'h0, 20); chk(contact, 1'h0, "clear");
    send(2'h1, 300);
    repeat (6) @(posedge ref_clk);
    chk(contact, 1'h0, "early");
    wait_c(1'h1, 40); chk(contact, 1'h1, "or contact");
    chk(buzz, 1'h1, "buzz on");
    chk(sounding, 1'h1, "sounding");
    rd(OFS_STATUS, got, rsp); chk(got[7:4], 4'h2, "ch alarms");
    send(2'h1, 50);
    wait_c(1'h0, 10); chk(contact, 1'h0, "follow");
    for (int i = 0; i < 2; i++) begin
      wreg(OFS_CTRL, ctl[i]);
      send(2'h1, 300);
      repeat (30) @(posedge ref_clk);
      chk(contact, 1'h0, "off ch");
      rd(OFS_STATUS, got, rsp); chk(got[1], 1'h0, "off viol");
    end
    wreg(OFS_CTRL, 32'h330);
    send(2'h1, 0);
    wreg(OFS_HYST, 32'ha);
    for (int i = 0; i < 4; i++) begin
      send(2'h0, hv[i]);
      rd(OFS_STATUS, got, rsp); chk(got[0], he[i], "hyst");
    end
    wreg(OFS_HYST, 32'h0);
    defrost <= 1'h1;
    wreg(OFS_CTRL, 32'h332);
    send(2'h0, -300);
    repeat (30) @(posedge ref_clk);
    chk(contact, 1'h0, "defrost hold");
    wait_c(1'h1, 120); chk(contact, 1'h1, "defrost alarm");
    chk(buzz, 1'h0, "buzz off");
    chk(buzz_h, 1'h1, "buzz forced");
    send(2'h0, 0);
    defrost <= 1'h0;
    wait_c(1'h0, 10);
    wreg(OFS_CTRL, 32'h331);
    n_cl = closures;
    send(2'h0, 300);
    wait_c(1'h1, 40);
    send(2'h0, 0);
    repeat (10) @(posedge ref_clk);
    chk(contact, 1'h1, "latched");
    chk(text, 1'h1, "text");
    chk(closures, 16'(n_cl + 1), "one closure");
    v = n_ack;
    wreg(OFS_CMD, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk(n_ack, v + 1, "ack");
    chk({contact, text}, 2'h0, "unlatch");
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict;
  end
endmodule
